// *** rcs_checker.sv ***
// Checker for bus handshake, reset steering and wake outcomes
`timescale 1ns/1ps
module rcs_checker #(
	parameter ADR_W = 14,
	parameter DAT_W = 32
) (
	// Clock and reset
	input wire             clk_i,
	input wire             rst_i,
	// Bus
	input wire             wb_cyc_i,
	input wire             wb_stb_i,
	input wire [DAT_W-1:0] wb_dat_o,
	input wire             wb_ack_o,
	// Events and levels
	input wire             brownout_evt_i,
	input wire             wdt_timeout_rst_i,
	input wire             wdt_window_viol_i,
	input wire             wdt_wake_i,
	input wire             irq_wake_i,
	input wire             pin_reset_i,
	input wire             reset_instr_i,
	input wire             stack_ovf_i,
	input wire             stack_unf_i,
	input wire             mem_viol_i,
	input wire             sleeping_i,
	input wire             stack_fault_reset_enable_i,
	input wire [1:0]       brownout_config_i,
	// Steering and status
	input wire             core_reset_o,
	input wire             pc_load_o,
	input wire [14:0]      pc_target_o,
	input wire             pc_next_o,
	input wire             irq_push_o,
	input wire             timeout_status_o,
	input wire             powerdown_status_o,
	input wire             brownout_enable_o
);
	// Events that restart the core; a wake loses to any of them
	wire rst_evt = brownout_evt_i | wdt_timeout_rst_i | wdt_window_viol_i | pin_reset_i
		| reset_instr_i | mem_viol_i | (stack_fault_reset_enable_i & (stack_ovf_i | stack_unf_i));
	wire wake_ok = sleeping_i & ~rst_evt;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_rise; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("ack late");
	property p_ack_fall; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_fall: assert property (p_ack_fall) else $error("ack too long");
	property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");
	property p_steer; rst_evt |=> core_reset_o && pc_load_o && pc_target_o == 15'h0000; endproperty
	a_steer: assert property (p_steer) else $error("no restart");
	property p_cause; core_reset_o |-> $past(rst_evt) || $past(rst_i); endproperty
	a_cause: assert property (p_cause) else $error("stray restart");
	property p_wdt_wake;
		wdt_wake_i && wake_ok |=> pc_next_o && !timeout_status_o && !powerdown_status_o;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("wdt wake wrong");
	property p_irq_wake;
		irq_wake_i && wake_ok |=> pc_next_o && timeout_status_o && !powerdown_status_o;
	endproperty
	a_irq_wake: assert property (p_irq_wake) else $error("irq wake wrong");
	property p_next; pc_next_o |-> $past(wdt_wake_i || irq_wake_i); endproperty
	a_next: assert property (p_next) else $error("stray resume");
	property p_vector; irq_push_o |=> pc_load_o && pc_target_o == 15'h0004; endproperty
	a_vector: assert property (p_vector) else $error("no vector");
	property p_bor;
		(brownout_config_i == 2'h3 || brownout_config_i == 2'h0) && $stable(brownout_config_i)
		|-> brownout_enable_o == (brownout_config_i == 2'h3);
	endproperty
	a_bor: assert property (p_bor) else $error("brownout enable wrong");
endmodule
bind rcs_top rcs_checker #(.ADR_W(ADR_W), .DAT_W(DAT_W)) rcs_checker_i (.clk_i, .rst_i,
	.wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .brownout_evt_i, .wdt_timeout_rst_i,
	.wdt_window_viol_i, .wdt_wake_i, .irq_wake_i, .pin_reset_i, .reset_instr_i, .stack_ovf_i,
	.stack_unf_i, .mem_viol_i, .sleeping_i, .stack_fault_reset_enable_i, .brownout_config_i,
	.core_reset_o, .pc_load_o, .pc_target_o, .pc_next_o, .irq_push_o, .timeout_status_o,
	.powerdown_status_o, .brownout_enable_o);

// *** rcs_defs.vh ***
// Register indices, field positions and reset values of the reset-cause block
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH

// Register indices; byte address is four times the index
`define RCS_IDX_BORCTL 12'h811
`define RCS_IDX_POWER_CONTROL_0  12'h813
`define RCS_IDX_POWER_CONTROL_1  12'h814

// Field positions
`define RCS_BIT_SWBOR  3'h7
`define RCS_BIT_BRDY   3'h0
`define RCS_BIT_MEM_VIOLATION_FLAG   3'h1
`define RCS_BIT_OVF    3'h7
`define RCS_BIT_UNF    3'h6
`define RCS_BIT_WV     3'h5
`define RCS_BIT_WATCHDOG_RESET_FLAG   3'h4
`define RCS_BIT_PIN    3'h3
`define RCS_BIT_RI     3'h2
`define RCS_BIT_POR    3'h1
`define RCS_BIT_BOR    3'h0

// Power-control 0 values: after power-on, after brown-out, which bits
// brown-out loads, and the value each bit's hardware event writes
`define RCS_P0_POR     8'h3D
`define RCS_P0_BORV    8'h3C
`define RCS_P0_BMASK   8'hFD
`define RCS_P0_HWV     8'hC0

// Single-bit reset and hardware-event values
`define RCS_P1_POR     1'h1
`define RCS_MEM_VIOLATION_FLAG_HWV   1'h0
`define RCS_SWBOR_RST  1'h1
`define RCS_STAT_RST   1'h1

// Brown-out configuration codes
`define RCS_BCFG_OFF   2'h0
`define RCS_BCFG_SW    2'h1
`define RCS_BCFG_AWAKE 2'h2
`define RCS_BCFG_ON    2'h3

// Program counter targets
`define RCS_PC_ZERO    15'h0000
`define RCS_PC_VECTOR  15'h0004

`endif

// *** rcs_flag.v ***
// One reset-cause flag with init load, hardware event and firmware write
`timescale 1ns/1ps
module rcs_flag #(
	parameter RST_VAL = 1'b1,
	parameter HW_VAL  = 1'b0
) (
	// Clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// Brown-out style load
	input  wire load_i,
	input  wire load_val_i,
	// Hardware event
	input  wire hw_i,
	// Firmware write
	input  wire sw_we_i,
	input  wire sw_val_i,
	// Flag value
	output reg  flag_o
);

	// Hardware wins over a firmware write in the same cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			flag_o <= RST_VAL;
		end else if (load_i) begin
			flag_o <= load_val_i;
		end else if (hw_i) begin
			flag_o <= HW_VAL; // R24
		end else if (sw_we_i) begin
			flag_o <= sw_val_i;
		end
	end

endmodule

// *** rcs_top.v ***
// Reset-cause recording registers with Wishbone slave and core steering
`timescale 1ns/1ps
`include "rcs_defs.vh"

// Functional notes
// R01: Watchdog wake resumes next address, clears status
// R02: Window violation resets, clears its flag
// R03: Interrupt wake resumes next, sets timeout status
// R04: Reset instruction resets, clears bit 2
// R05: Enabled stack overflow resets, sets bit 7
// R06: Enabled stack underflow resets, sets bit 6
// R07: Memory violation resets, clears its flag
// R08: Interrupt wake with enable then vectors
// R09: Software enable acts only under config 01
// R10: Software enable bit 7, one after power-up
// R11: Ready bit reads armed state
// R12: Power-control 0 flags with power-on values
// R13: Overflow flag set by hardware, firmware clears
// R14: Underflow flag set by hardware, firmware clears
// R15: Window flag cleared by hardware, firmware sets
// R16: Watchdog flag cleared on time-out reset
// R17: Pin flag cleared on external reset
// R18: Unimplemented bits read zero, others keep
// R19: Reset-instruction flag cleared by instruction
// R20: Power-on flag cleared on power-on
// R21: Brown-out flag cleared on brown-out
// R22: Memory flag cleared on violation
// R23: Flags captured before core leaves reset
// R24: Hardware event beats firmware write
module rcs_top #(
	parameter ADR_W = 14,
	parameter DAT_W = 32
) (
	// Clock and power-on reset
	input  wire             clk_i,
	input  wire             rst_i,
	// Wishbone slave
	input  wire             wb_cyc_i,
	input  wire             wb_stb_i,
	input  wire             wb_we_i,
	input  wire [ADR_W-1:0] wb_adr_i,
	input  wire [3:0]       wb_sel_i,
	input  wire [DAT_W-1:0] wb_dat_i,
	output reg  [DAT_W-1:0] wb_dat_o,
	output reg              wb_ack_o,
	// Reset and wake events, one-cycle pulses
	input  wire             brownout_evt_i,
	input  wire             wdt_timeout_rst_i,
	input  wire             wdt_window_viol_i,
	input  wire             wdt_wake_i,
	input  wire             irq_wake_i,
	input  wire             pin_reset_i,
	input  wire             reset_instr_i,
	input  wire             stack_ovf_i,
	input  wire             stack_unf_i,
	input  wire             mem_viol_i,
	input  wire             watchdog_clear_instr_i,
	input  wire             sleep_enter_i,
	// Core and configuration levels
	input  wire             sleeping_i,
	input  wire             stack_fault_reset_enable_i,
	input  wire             global_irq_enable_i,
	input  wire [1:0]       brownout_config_i,
	input  wire             brownout_armed_i,
	input  wire             instr_done_i,
	// Core steering
	output reg              core_reset_o,
	output reg              pc_load_o,
	output reg  [14:0]      pc_target_o,
	output wire             pc_next_o,
	output wire             irq_push_o,
	// Status and brown-out control
	output reg              timeout_status_o,
	output reg              powerdown_status_o,
	output reg              brownout_enable_o
);

	localparam [7:0] P0_POR   = `RCS_P0_POR;
	localparam [7:0] P0_BORV  = `RCS_P0_BORV;
	localparam [7:0] P0_BMASK = `RCS_P0_BMASK;
	localparam [7:0] P0_HWV   = `RCS_P0_HWV;

	wire [7:0]  power_control_0;
	wire        mem_violation_flag;
	reg         sw_brownout_enable;
	wire [11:0] reg_idx;
	wire        req;
	wire        wr_commit;
	wire        hit_bctl;
	wire        hit_p0;
	wire        hit_p1;
	wire        p0_we;
	wire        p1_we;
	wire        ovf_rst;
	wire        unf_rst;
	wire        any_rst;
	wire        wake;
	reg  [7:0]  rd_byte;

	// Address decode; offsets are indices, so the byte address is 4x
	assign reg_idx  = wb_adr_i[ADR_W-1:2];
	assign req      = wb_cyc_i && wb_stb_i;
	assign hit_bctl = (reg_idx == `RCS_IDX_BORCTL);
	assign hit_p0   = (reg_idx == `RCS_IDX_POWER_CONTROL_0);
	assign hit_p1   = (reg_idx == `RCS_IDX_POWER_CONTROL_1);

	// Write lands on the edge where the master sees ack
	assign wr_commit = req && wb_we_i && wb_ack_o && wb_sel_i[0];
	assign p0_we     = wr_commit && hit_p0;
	assign p1_we     = wr_commit && hit_p1;

	// Stack faults only reset the core when enabled
	assign ovf_rst = stack_ovf_i && stack_fault_reset_enable_i; // R05
	assign unf_rst = stack_unf_i && stack_fault_reset_enable_i; // R06

	// Every event that restarts the core at address zero
	assign any_rst = brownout_evt_i | wdt_timeout_rst_i | wdt_window_viol_i
		| pin_reset_i | reset_instr_i | ovf_rst | unf_rst | mem_viol_i;
	assign wake = wdt_wake_i | irq_wake_i;

	// Stack overflow: set by hardware, cleared by firmware
	rcs_flag #(
		.RST_VAL (P0_POR[`RCS_BIT_OVF]),
		.HW_VAL  (P0_HWV[`RCS_BIT_OVF])
	) u_ovf (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (brownout_evt_i && P0_BMASK[`RCS_BIT_OVF]),
		.load_val_i (P0_BORV[`RCS_BIT_OVF]),
		.hw_i       (stack_ovf_i), // R13
		.sw_we_i    (p0_we),
		.sw_val_i   (wb_dat_i[`RCS_BIT_OVF]),
		.flag_o     (power_control_0[`RCS_BIT_OVF])
	);

	// Stack underflow: set by hardware, zero after power-up
	rcs_flag #(
		.RST_VAL (P0_POR[`RCS_BIT_UNF]),
		.HW_VAL  (P0_HWV[`RCS_BIT_UNF])
	) u_unf (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (brownout_evt_i && P0_BMASK[`RCS_BIT_UNF]),
		.load_val_i (P0_BORV[`RCS_BIT_UNF]),
		.hw_i       (stack_unf_i), // R14
		.sw_we_i    (p0_we),
		.sw_val_i   (wb_dat_i[`RCS_BIT_UNF]),
		.flag_o     (power_control_0[`RCS_BIT_UNF])
	);

	// Window violation: cleared by hardware
	rcs_flag #(
		.RST_VAL (P0_POR[`RCS_BIT_WV]),
		.HW_VAL  (P0_HWV[`RCS_BIT_WV])
	) u_wv (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (brownout_evt_i && P0_BMASK[`RCS_BIT_WV]),
		.load_val_i (P0_BORV[`RCS_BIT_WV]),
		.hw_i       (wdt_window_viol_i), // R02 R15
		.sw_we_i    (p0_we),
		.sw_val_i   (wb_dat_i[`RCS_BIT_WV]),
		.flag_o     (power_control_0[`RCS_BIT_WV])
	);

	// Watchdog time-out: back to one on brown-out like power-on
	rcs_flag #(
		.RST_VAL (P0_POR[`RCS_BIT_WATCHDOG_RESET_FLAG]),
		.HW_VAL  (P0_HWV[`RCS_BIT_WATCHDOG_RESET_FLAG])
	) u_watchdog_reset_flag (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (brownout_evt_i && P0_BMASK[`RCS_BIT_WATCHDOG_RESET_FLAG]),
		.load_val_i (P0_BORV[`RCS_BIT_WATCHDOG_RESET_FLAG]),
		.hw_i       (wdt_timeout_rst_i), // R16
		.sw_we_i    (p0_we),
		.sw_val_i   (wb_dat_i[`RCS_BIT_WATCHDOG_RESET_FLAG]),
		.flag_o     (power_control_0[`RCS_BIT_WATCHDOG_RESET_FLAG])
	);

	// External pin reset
	rcs_flag #(
		.RST_VAL (P0_POR[`RCS_BIT_PIN]),
		.HW_VAL  (P0_HWV[`RCS_BIT_PIN])
	) u_pin (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (brownout_evt_i && P0_BMASK[`RCS_BIT_PIN]),
		.load_val_i (P0_BORV[`RCS_BIT_PIN]),
		.hw_i       (pin_reset_i), // R17
		.sw_we_i    (p0_we),
		.sw_val_i   (wb_dat_i[`RCS_BIT_PIN]),
		.flag_o     (power_control_0[`RCS_BIT_PIN])
	);

	// Reset instruction
	rcs_flag #(
		.RST_VAL (P0_POR[`RCS_BIT_RI]),
		.HW_VAL  (P0_HWV[`RCS_BIT_RI])
	) u_ri (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (brownout_evt_i && P0_BMASK[`RCS_BIT_RI]),
		.load_val_i (P0_BORV[`RCS_BIT_RI]),
		.hw_i       (reset_instr_i), // R04 R19
		.sw_we_i    (p0_we),
		.sw_val_i   (wb_dat_i[`RCS_BIT_RI]),
		.flag_o     (power_control_0[`RCS_BIT_RI])
	);

	// Power-on: cleared by rst_i itself, kept by brown-out
	rcs_flag #(
		.RST_VAL (P0_POR[`RCS_BIT_POR]), // R20
		.HW_VAL  (P0_HWV[`RCS_BIT_POR])
	) u_por (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (brownout_evt_i && P0_BMASK[`RCS_BIT_POR]),
		.load_val_i (P0_BORV[`RCS_BIT_POR]),
		.hw_i       (1'b0),
		.sw_we_i    (p0_we),
		.sw_val_i   (wb_dat_i[`RCS_BIT_POR]),
		.flag_o     (power_control_0[`RCS_BIT_POR])
	);

	// Brown-out: cleared by the brown-out load
	rcs_flag #(
		.RST_VAL (P0_POR[`RCS_BIT_BOR]),
		.HW_VAL  (P0_HWV[`RCS_BIT_BOR])
	) u_bor (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (brownout_evt_i && P0_BMASK[`RCS_BIT_BOR]), // R21
		.load_val_i (P0_BORV[`RCS_BIT_BOR]),
		.hw_i       (1'b0),
		.sw_we_i    (p0_we),
		.sw_val_i   (wb_dat_i[`RCS_BIT_BOR]),
		.flag_o     (power_control_0[`RCS_BIT_BOR])
	);

	// Memory violation, the only implemented bit of power-control 1
	rcs_flag #(
		.RST_VAL (`RCS_P1_POR),
		.HW_VAL  (`RCS_MEM_VIOLATION_FLAG_HWV)
	) u_mem_violation_flag (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (1'b0),
		.load_val_i (`RCS_P1_POR),
		.hw_i       (mem_viol_i), // R07 R22
		.sw_we_i    (p1_we),
		.sw_val_i   (wb_dat_i[`RCS_BIT_MEM_VIOLATION_FLAG]),
		.flag_o     (mem_violation_flag)
	);

	// Software brown-out enable; kept by every reset but power-on/brown-out
	always @(posedge clk_i) begin
		if (rst_i) begin
			sw_brownout_enable <= `RCS_SWBOR_RST; // R10
		end else if (brownout_evt_i) begin
			sw_brownout_enable <= `RCS_SWBOR_RST;
		end else if (wr_commit && hit_bctl) begin
			sw_brownout_enable <= wb_dat_i[`RCS_BIT_SWBOR]; // R10
		end
	end

	// Brown-out enable; the software bit only counts under config 01
	always @(posedge clk_i) begin
		if (rst_i) begin
			brownout_enable_o <= 1'b1;
		end else begin
			case (brownout_config_i)
				`RCS_BCFG_SW:    brownout_enable_o <= sw_brownout_enable; // R09
				`RCS_BCFG_ON:    brownout_enable_o <= 1'b1;
				`RCS_BCFG_AWAKE: brownout_enable_o <= !sleeping_i;
				default:         brownout_enable_o <= 1'b0;
			endcase
		end
	end

	// Time-out and power-down status; order follows event precedence
	always @(posedge clk_i) begin
		if (rst_i || brownout_evt_i) begin
			timeout_status_o   <= `RCS_STAT_RST;
			powerdown_status_o <= `RCS_STAT_RST;
		end else if (wdt_timeout_rst_i) begin
			timeout_status_o <= 1'b0; // Pd kept on a time-out reset
		end else if (wdt_wake_i) begin
			timeout_status_o   <= 1'b0; // R01
			powerdown_status_o <= 1'b0; // R01
		end else if (irq_wake_i) begin
			timeout_status_o   <= 1'b1; // R03
			powerdown_status_o <= 1'b0; // R03
		end else if (pin_reset_i && sleeping_i) begin
			timeout_status_o   <= 1'b1;
			powerdown_status_o <= 1'b0;
		end else if (watchdog_clear_instr_i) begin
			timeout_status_o   <= 1'b1;
			powerdown_status_o <= 1'b1;
		end else if (sleep_enter_i) begin
			timeout_status_o   <= 1'b1;
			powerdown_status_o <= 1'b0;
		end
	end

	// Core held in reset for one cycle, from the same edge on which the flags capture the cause
	always @(posedge clk_i) begin
		if (rst_i) begin
			core_reset_o <= 1'b1;
			pc_load_o    <= 1'b1;
			pc_target_o  <= `RCS_PC_ZERO;
		end else begin
			core_reset_o <= any_rst; // R23
			pc_load_o    <= any_rst | irq_push_o;
			if (any_rst) begin
				pc_target_o <= `RCS_PC_ZERO; // R02 R04 R05 R06 R07
			end else if (irq_push_o) begin
				pc_target_o <= `RCS_PC_VECTOR; // R08
			end
		end
	end

	// Wake steps to the next address, with a vector jump after it for an enabled interrupt wake
	rcs_wake_seq u_wake (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.wake_i       (wake && !any_rst),
		.vec_req_i    (irq_wake_i && global_irq_enable_i), // R08
		.instr_done_i (instr_done_i),
		.abort_i      (any_rst),
		.pc_next_o    (pc_next_o),
		.irq_push_o   (irq_push_o)
	);

	// Read mux; unused and unmapped bits read zero
	always @* begin
		rd_byte = 8'h00; // R18
		if (hit_bctl) begin
			rd_byte[`RCS_BIT_SWBOR] = sw_brownout_enable;
			rd_byte[`RCS_BIT_BRDY]  = brownout_armed_i; // R11
		end else if (hit_p0) begin
			rd_byte = power_control_0; // R12
		end else if (hit_p1) begin
			rd_byte[`RCS_BIT_MEM_VIOLATION_FLAG] = mem_violation_flag;
		end
	end

	// Classic single-cycle ack, dropped the cycle after it is given
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= {DAT_W{1'b0}};
		end else begin
			wb_ack_o <= req && !wb_ack_o;
			wb_dat_o <= {{(DAT_W-8){1'b0}}, rd_byte};
		end
	end

endmodule

// *** rcs_wake_seq.v ***
// Wake-up sequencer: step to next address, then optional vector jump
`timescale 1ns/1ps
module rcs_wake_seq (
	// Clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// Wake events
	input  wire wake_i,
	input  wire vec_req_i,
	input  wire instr_done_i,
	input  wire abort_i,
	// Core steering
	output reg  pc_next_o,
	output reg  irq_push_o
);

	localparam S_IDLE = 3'b001;
	localparam S_STEP = 3'b010;
	localparam S_PUSH = 3'b100;

	reg [2:0] state;
	reg [2:0] next_state;

	// Next state; a reset event aborts any pending vector jump
	always @* begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (wake_i && vec_req_i) begin
					next_state = S_STEP;
				end
			end
			S_STEP: begin
				if (abort_i) begin
					next_state = S_IDLE;
				end else if (instr_done_i) begin
					next_state = S_PUSH; // R08
				end
			end
			S_PUSH: begin
				next_state = S_IDLE;
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	// State and registered pulses
	always @(posedge clk_i) begin
		if (rst_i) begin
			state      <= S_IDLE;
			pc_next_o  <= 1'b0;
			irq_push_o <= 1'b0;
		end else begin
			state      <= next_state;
			pc_next_o  <= wake_i && !abort_i; // R01 R03
			irq_push_o <= (state == S_STEP) && instr_done_i && !abort_i; // R08
		end
	end

endmodule

// *** tb.sv ***
// Self-checking bench for the reset-cause registers
`timescale 1ns/1ps
module tb;
	reg         clk_i = 1'b0;
	reg         rst_i = 1'b1;
	reg         cyc = 1'b0;
	reg         we = 1'b0;
	reg  [13:0] adr = 14'h0000;
	reg  [3:0]  sel = 4'hF;
	reg  [31:0] wdat = 32'h0;
	reg  [12:0] ev = 13'h0;
	reg         slp = 1'b0;
	reg  [1:0]  cfg = 2'h1;
	reg         armed = 1'b0;
	reg         sfe = 1'b1;
	reg         global_irq_enable = 1'b1;
	reg  [31:0] rd;
	wire [31:0] rdat;
	wire        ack, cr, pl, pn, ip, tos, pds, boe;
	wire [14:0] pt;
	integer     err_count = 0;
	integer     n_checks = 0;
	integer     cyc_cnt = 0;
	rcs_top rcs_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .brownout_evt_i(ev[0]), .wdt_timeout_rst_i(ev[1]),
		.wdt_window_viol_i(ev[2]), .wdt_wake_i(ev[3]), .irq_wake_i(ev[4]),
		.pin_reset_i(ev[5]), .reset_instr_i(ev[6]), .stack_ovf_i(ev[7]), .stack_unf_i(ev[8]),
		.mem_viol_i(ev[9]), .watchdog_clear_instr_i(ev[10]), .sleep_enter_i(ev[11]),
		.sleeping_i(slp), .stack_fault_reset_enable_i(sfe), .global_irq_enable_i(global_irq_enable),
		.brownout_config_i(cfg), .brownout_armed_i(armed), .instr_done_i(ev[12]),
		.core_reset_o(cr), .pc_load_o(pl), .pc_target_o(pt), .pc_next_o(pn),
		.irq_push_o(ip), .timeout_status_o(tos), .powerdown_status_o(pds),
		.brownout_enable_o(boe));
	// Clock and hang guard; whole run is a few hundred cycles
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc_cnt = cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			err_count = err_count + 1;
			$display("ERROR %0t timeout", $time);
			end_sim;
		end
	end
	task end_sim;
		begin
			$display("checks %0d errors %0d", n_checks, err_count);
			if (err_count == 0 && n_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("ERROR %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	// Classic cycle; request held until ack is sampled high
	task bus(input w, input [13:0] a, input [31:0] d);
		begin
			@(posedge clk_i);
			cyc <= 1'b1;
			we <= w;
			adr <= a;
			wdat <= d;
			@(posedge clk_i);
			while (ack !== 1'b1) @(posedge clk_i);
			rd = rdat;
			cyc <= 1'b0;
			we <= 1'b0;
		end
	endtask
	task expect_rd(input [13:0] a, input [31:0] e);
		begin
			bus(1'b0, a, 32'h0);
			chk(rd, e);
		end
	endtask
	task pulse(input integer k);
		begin
			@(posedge clk_i);
			ev <= 13'h1 << k;
			@(posedge clk_i);
			ev <= 13'h0;
		end
	endtask
	// Power-on values, reserved word, ignored writes
	task t_reset;
		begin
			expect_rd(14'h2044, 32'h80);
			expect_rd(14'h204C, 32'h3D);
			expect_rd(14'h2050, 32'h02);
			bus(1'b1, 14'h2048, 32'hFF);
			expect_rd(14'h2048, 32'h0);
			sel <= 4'hE;
			bus(1'b1, 14'h204C, 32'h00);
			sel <= 4'hF;
			expect_rd(14'h204C, 32'h3D);
		end
	endtask
	// Firmware access to every flag
	task t_rw;
		begin
			armed <= 1'b1;
			bus(1'b1, 14'h2044, 32'h00);
			expect_rd(14'h2044, 32'h01);
			bus(1'b1, 14'h204C, 32'h00);
			expect_rd(14'h204C, 32'h00);
			bus(1'b1, 14'h204C, 32'hFF);
			expect_rd(14'h204C, 32'hFF);
			bus(1'b1, 14'h2050, 32'hFD);
			expect_rd(14'h2050, 32'h00);
		end
	endtask
	// Each reset cause but brown-out touches only its own flag; brown-out reloads power-control 0 except the power-on bit; read right after restart
	task t_events;
		integer i;
		reg [33:0] row;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				case (i)
					0: row = {4'h2, 14'h204C, 8'hFF, 8'hDF};
					1: row = {4'h1, 14'h204C, 8'hFF, 8'hEF};
					2: row = {4'h5, 14'h204C, 8'hFF, 8'hF7};
					3: row = {4'h6, 14'h204C, 8'hFF, 8'hFB};
					4: row = {4'h7, 14'h204C, 8'h00, 8'h80};
					5: row = {4'h8, 14'h204C, 8'h00, 8'h40};
					6: row = {4'h9, 14'h2050, 8'hFF, 8'h00};
					default: row = {4'h0, 14'h204C, 8'hEF, 8'h3E};
				endcase
				bus(1'b1, row[29:16], {24'h0, row[15:8]});
				pulse(row[33:30]);
				expect_rd(row[29:16], {24'h0, row[7:0]});
			end
		end
	endtask
	// Wakes keep flags; interrupt wake then vectors
	task t_wake;
		begin
			slp <= 1'b1;
			pulse(11);
			bus(1'b1, 14'h204C, 32'h5A);
			pulse(3);
			expect_rd(14'h204C, 32'h5A);
			pulse(4);
			slp <= 1'b0;
			pulse(12);
			@(posedge clk_i);
			chk({31'h0, ip}, 32'h1);
			@(posedge clk_i);
			chk({16'h0, pl, pt}, 32'h8004);
			expect_rd(14'h204C, 32'h5A);
			pulse(10);
			@(posedge clk_i);
			chk({30'h0, tos, pds}, 32'h3);
		end
	endtask
	// Software enable matters only under configuration 01
	task t_bor;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				cfg <= i[1:0];
				bus(1'b1, 14'h2044, {24'h0, i[2], 7'h0});
				repeat (2) @(posedge clk_i);
				chk({31'h0, boe}, (i[1:0] == 2'h1) ? i[2] : (i[1:0] != 2'h0));
			end
		end
	endtask
	// Write and window event held together up to the commit edge
	task t_collide;
		begin
			@(posedge clk_i);
			cyc <= 1'b1;
			we <= 1'b1;
			adr <= 14'h204C;
			wdat <= 32'hFF;
			ev <= 13'h4;
			@(posedge clk_i);
			while (ack !== 1'b1) @(posedge clk_i);
			chk({31'h0, cr}, 32'h1);
			cyc <= 1'b0;
			we <= 1'b0;
			ev <= 13'h0;
			expect_rd(14'h204C, 32'hDF);
		end
	endtask
	// Disabled stack reset and interrupt enable; status on sleep resets
	task t_gate;
		begin
			sfe <= 1'b0;
			global_irq_enable <= 1'b0;
			slp <= 1'b1;
			bus(1'b1, 14'h204C, 32'h00);
			pulse(7);
			@(posedge clk_i);
			chk({31'h0, cr}, 32'h0);
			expect_rd(14'h204C, 32'h80);
			pulse(4);
			@(posedge clk_i);
			chk({31'h0, pn}, 32'h1);
			pulse(12);
			@(posedge clk_i);
			chk({31'h0, ip}, 32'h0);
			pulse(10);
			pulse(5);
			@(posedge clk_i);
			chk({30'h0, tos, pds}, 32'h2);
			pulse(1);
			@(posedge clk_i);
			chk({30'h0, tos, pds}, 32'h0);
			sfe <= 1'b1;
			global_irq_enable <= 1'b1;
			slp <= 1'b0;
		end
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_rw;
		t_events;
		t_wake;
		t_bor;
		t_collide;
		t_gate;
		end_sim;
	end
endmodule
